// [hw/pmux_defs.vh]
// Constants of the pin output multiplexer and encoder input filter
`ifndef PMUX_DEFS_VH
`define PMUX_DEFS_VH

// ====================================================================
// Register byte offsets
`define PMUX_OFS_SEL0     6'h00
`define PMUX_OFS_SEL1     6'h04
`define PMUX_OFS_SEL2     6'h08
`define PMUX_OFS_SEL3     6'h0c
`define PMUX_OFS_SEL4     6'h10
`define PMUX_OFS_SEL5     6'h14
`define PMUX_OFS_SEL6     6'h18
`define PMUX_OFS_FILT     6'h20
`define PMUX_OFS_KILL     6'h24

// ====================================================================
// Reset values
`define PMUX_RST_SEL0     32'h00000100
`define PMUX_RST_SEL1     32'h01010101
`define PMUX_RST_SEL2     32'h00010101
`define PMUX_RST_SEL3     32'h01010001
`define PMUX_RST_SEL4     32'h00010101
`define PMUX_RST_SEL5     32'h00000100
`define PMUX_RST_SEL6     32'h00000100
`define PMUX_RST_FILT     32'h01010101
`define PMUX_RST_KILL     32'h00000001

// ====================================================================
// Implemented bits, all others reserved and read as zero
`define PMUX_MSK_SEL0     32'h00000300
`define PMUX_MSK_SEL1     32'h03030303
`define PMUX_MSK_SEL2     32'h00030703
`define PMUX_MSK_SEL3     32'h03030007
`define PMUX_MSK_SEL4     32'h00030303
`define PMUX_MSK_SEL5     32'h00000700
`define PMUX_MSK_SEL6     32'h00000700
`define PMUX_MSK_FILT     32'h03030303
`define PMUX_MSK_KILL     32'h00000003

// ====================================================================
// Selection byte codes and field positions
`define PMUX_CODE_OPT2    8'h02
`define PMUX_CODE_OPT3    8'h04
`define PMUX_POS_FILT_A   0
`define PMUX_POS_FILT_B   8
`define PMUX_POS_FILT_I   16
`define PMUX_POS_FILT_S   24
`define PMUX_POS_KILL_GPIO 0
`define PMUX_POS_KILL_ERR 1

// ====================================================================
// Pins with a third option (table order)
`define PMUX_HAS_OPT3     16'h0b40

// ====================================================================
// Avalon responses
`define PMUX_RSP_OK       2'h0
`define PMUX_RSP_SLVERR   2'h2
`define PMUX_RSP_DECERR   2'h3

// ====================================================================
// Qualifier counter
`define PMUX_QUAL_WIDTH   6

`endif

// [hw/pmux_top.v]
// Pin output multiplexer with encoder input filtering and Avalon-MM control registers
`timescale 1ns/1ps
`include "pmux_defs.vh"

module pmux_top #(
	parameter NPINS = 16,
	parameter QW    = `PMUX_QUAL_WIDTH
) (
	mclk,
	rst,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_byteenable,
	avs_priv,
	avs_readdata,
	avs_waitrequest,
	avs_response,
	pin_def_o,
	pin_def_oe,
	pin_opt2_o,
	pin_opt2_oe,
	pin_opt3_o,
	pin_opt3_oe,
	pad_o,
	pad_oe,
	pad_i,
	periph_in,
	encoder_phase_a,
	encoder_phase_b,
	encoder_index,
	encoder_strobe,
	encoder_error,
	port_a_bit5,
	enc_a_filt,
	enc_b_filt,
	enc_i_filt,
	enc_s_filt,
	timer_output_kill_n
);

	input  wire             mclk;
	input  wire             rst;
	input  wire [5:0]       avs_address;
	input  wire             avs_read;
	input  wire             avs_write;
	input  wire [31:0]      avs_writedata;
	input  wire [3:0]       avs_byteenable;
	input  wire             avs_priv;
	output wire [31:0]      avs_readdata;
	output wire             avs_waitrequest;
	output wire [1:0]       avs_response;
	input  wire [NPINS-1:0] pin_def_o;
	input  wire [NPINS-1:0] pin_def_oe;
	input  wire [NPINS-1:0] pin_opt2_o;
	input  wire [NPINS-1:0] pin_opt2_oe;
	input  wire [NPINS-1:0] pin_opt3_o;
	input  wire [NPINS-1:0] pin_opt3_oe;
	output reg  [NPINS-1:0] pad_o;
	output reg  [NPINS-1:0] pad_oe;
	input  wire [NPINS-1:0] pad_i;
	output wire [NPINS-1:0] periph_in;
	input  wire             encoder_phase_a;
	input  wire             encoder_phase_b;
	input  wire             encoder_index;
	input  wire             encoder_strobe;
	input  wire             encoder_error;
	input  wire             port_a_bit5;
	output wire             enc_a_filt;
	output wire             enc_b_filt;
	output wire             enc_i_filt;
	output wire             enc_s_filt;
	output wire             timer_output_kill_n;

	// ====================================================================
	// Register storage
	reg  [31:0] sel0_q;
	reg  [31:0] sel1_q;
	reg  [31:0] sel2_q;
	reg  [31:0] sel3_q;
	reg  [31:0] sel4_q;
	reg  [31:0] sel5_q;
	reg  [31:0] sel6_q;
	reg  [31:0] filt_q;
	reg  [31:0] kill_q;
	reg         ack_q;
	reg  [31:0] rdata_q;
	reg  [1:0]  rsp_q;
	reg  [31:0] rdata_d;
	reg  [1:0]  rsp_d;
	reg         hit_d;
	wire        req;
	wire        wr_go;

	// ====================================================================
	// Functions
	// Merge byte lanes of a write into a register, dropping reserved bits
	function [31:0] merge;
		input [31:0] old;
		input [31:0] wdat;
		input [3:0]  be;
		input [31:0] msk;
		reg   [31:0] bm;
		begin
			bm    = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
			merge = ((old & ~bm) | (wdat & bm)) & msk;
		end
	endfunction

	// Option chosen by one bit; zero or several bits mean default
	function [1:0] pick;
		input [7:0] sb;
		input       has3;
		begin
			if (sb == `PMUX_CODE_OPT2) begin
				pick = 2'h1;
			end else if (has3 && (sb == `PMUX_CODE_OPT3)) begin
				pick = 2'h2;
			end else begin
				pick = 2'h0;
			end
		end
	endfunction

	// Qualify only when the sync-only bit is clear and the counter bit set
	function use_qual;
		input [1:0] f;
		begin
			use_qual = ~f[0] & f[1];
		end
	endfunction

	// ====================================================================
	// Avalon slave: one wait state for every access
	// Response and read data are registered in the wait cycle,
	// so they are settled when waitrequest drops
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata    = rdata_q;
	assign avs_response    = rsp_q;
	assign wr_go           = avs_write & ack_q & avs_priv & (rsp_q == `PMUX_RSP_OK);

	always @* begin
		rdata_d = 32'h00000000;
		hit_d   = 1'b1;
		case (avs_address & 6'h3c)
			`PMUX_OFS_SEL0: begin
				rdata_d = sel0_q;
			end
			`PMUX_OFS_SEL1: begin
				rdata_d = sel1_q;
			end
			`PMUX_OFS_SEL2: begin
				rdata_d = sel2_q;
			end
			`PMUX_OFS_SEL3: begin
				rdata_d = sel3_q;
			end
			`PMUX_OFS_SEL4: begin
				rdata_d = sel4_q;
			end
			`PMUX_OFS_SEL5: begin
				rdata_d = sel5_q;
			end
			`PMUX_OFS_SEL6: begin
				rdata_d = sel6_q;
			end
			`PMUX_OFS_FILT: begin
				rdata_d = filt_q;
			end
			`PMUX_OFS_KILL: begin
				rdata_d = kill_q;
			end
			default: begin
				hit_d = 1'b0;
			end
		endcase
		if (!hit_d) begin
			rsp_d = `PMUX_RSP_DECERR;
		end else if (avs_write && !avs_priv) begin
			rsp_d = `PMUX_RSP_SLVERR;
		end else begin
			rsp_d = `PMUX_RSP_OK;
		end
		if (avs_write) begin
			rdata_d = 32'h00000000;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
			rsp_q   <= `PMUX_RSP_OK;
		end else begin
			ack_q <= req & ~ack_q;
			if (req && !ack_q) begin
				rdata_q <= rdata_d;
				rsp_q   <= rsp_d;
			end else if (ack_q) begin
				rdata_q <= 32'h00000000;
				rsp_q   <= `PMUX_RSP_OK;
			end
		end
	end

	// ====================================================================
	// Control registers
	// Writes land at the edge that ends the answer cycle
	// Reserved bits are masked so they always read zero
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			sel0_q <= `PMUX_RST_SEL0;
			sel1_q <= `PMUX_RST_SEL1;
			sel2_q <= `PMUX_RST_SEL2;
			sel3_q <= `PMUX_RST_SEL3;
			sel4_q <= `PMUX_RST_SEL4;
			sel5_q <= `PMUX_RST_SEL5;
			sel6_q <= `PMUX_RST_SEL6;
			filt_q <= `PMUX_RST_FILT;
			kill_q <= `PMUX_RST_KILL;
		end else if (wr_go) begin
			case (avs_address & 6'h3c)
				`PMUX_OFS_SEL0: begin
					sel0_q <= merge(sel0_q, avs_writedata, avs_byteenable, `PMUX_MSK_SEL0);
				end
				`PMUX_OFS_SEL1: begin
					sel1_q <= merge(sel1_q, avs_writedata, avs_byteenable, `PMUX_MSK_SEL1);
				end
				`PMUX_OFS_SEL2: begin
					sel2_q <= merge(sel2_q, avs_writedata, avs_byteenable, `PMUX_MSK_SEL2);
				end
				`PMUX_OFS_SEL3: begin
					sel3_q <= merge(sel3_q, avs_writedata, avs_byteenable, `PMUX_MSK_SEL3);
				end
				`PMUX_OFS_SEL4: begin
					sel4_q <= merge(sel4_q, avs_writedata, avs_byteenable, `PMUX_MSK_SEL4);
				end
				`PMUX_OFS_SEL5: begin
					sel5_q <= merge(sel5_q, avs_writedata, avs_byteenable, `PMUX_MSK_SEL5);
				end
				`PMUX_OFS_SEL6: begin
					sel6_q <= merge(sel6_q, avs_writedata, avs_byteenable, `PMUX_MSK_SEL6);
				end
				`PMUX_OFS_FILT: begin
					filt_q <= merge(filt_q, avs_writedata, avs_byteenable, `PMUX_MSK_FILT);
				end
				`PMUX_OFS_KILL: begin
					kill_q <= merge(kill_q, avs_writedata, avs_byteenable, `PMUX_MSK_KILL);
				end
				default: begin
					kill_q <= kill_q;
				end
			endcase
		end
	end

	// ====================================================================
	// Selection bytes in pin table order
	// Byte index is the pad index, byte value its select field
	wire [8*16-1:0] sel_bytes;

	assign sel_bytes = {
		sel4_q[23:16], sel3_q[31:24], sel4_q[7:0],   sel3_q[23:16],
		sel5_q[15:8],  sel4_q[15:8],  sel3_q[7:0],   sel6_q[15:8],
		sel2_q[23:16], sel2_q[15:8],  sel2_q[7:0],   sel1_q[31:24],
		sel1_q[23:16], sel1_q[15:8],  sel1_q[7:0],   sel0_q[15:8]
	};

	// ====================================================================
	// Output buffer multiplexing
	// Zero, several or unknown codes fall back to the default function
	integer     p;
	reg  [1:0]  choice;
	reg  [15:0] has3_v;

	always @* begin
		has3_v = `PMUX_HAS_OPT3;
		choice = 2'h0;
		pad_o  = {NPINS{1'b0}};
		pad_oe = {NPINS{1'b0}};
		for (p = 0; p < NPINS; p = p + 1) begin
			choice = pick(sel_bytes[8*p +: 8], has3_v[p]);
			case (choice)
				2'h1: begin
					pad_o[p]  = pin_opt2_o[p];
					pad_oe[p] = pin_opt2_oe[p];
				end
				2'h2: begin
					pad_o[p]  = pin_opt3_o[p];
					pad_oe[p] = pin_opt3_oe[p];
				end
				default: begin
					pad_o[p]  = pin_def_o[p];
					pad_oe[p] = pin_def_oe[p];
				end
			endcase
		end
	end

	// Inputs are never multiplexed
	assign periph_in = pad_i;

	// ====================================================================
	// Encoder input synchronisers and qualifiers
	// Both paths run all the time, so a mode change never restarts
	// the synchroniser
	wire [3:0] enc_raw;
	wire [3:0] enc_out;
	wire [7:0] enc_mode;

	assign enc_raw  = {encoder_strobe, encoder_index, encoder_phase_b, encoder_phase_a};
	assign enc_mode = {filt_q[`PMUX_POS_FILT_S+1 -: 2], filt_q[`PMUX_POS_FILT_I+1 -: 2],
	                   filt_q[`PMUX_POS_FILT_B+1 -: 2], filt_q[`PMUX_POS_FILT_A+1 -: 2]};

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : enc_ch
			reg          meta_q;
			reg          sync_q;
			reg          qual_q;
			reg [QW-1:0] cnt_q;

			always @(posedge mclk or posedge rst) begin
				if (rst) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= enc_raw[g];
					sync_q <= meta_q;
				end
			end

			// Counter runs only while the synchronised level differs from the output
			always @(posedge mclk or posedge rst) begin
				if (rst) begin
					qual_q <= 1'b0;
					cnt_q  <= {QW{1'b0}};
				end else if (sync_q == qual_q) begin
					cnt_q <= {QW{1'b0}};
				end else if (cnt_q == {QW{1'b1}}) begin
					qual_q <= sync_q;
					cnt_q  <= {QW{1'b0}};
				end else begin
					cnt_q <= cnt_q + {{(QW-1){1'b0}}, 1'b1};
				end
			end

			assign enc_out[g] = use_qual(enc_mode[2*g +: 2]) ? qual_q : sync_q;
		end
	endgenerate

	assign enc_a_filt = enc_out[0];
	assign enc_b_filt = enc_out[1];
	assign enc_i_filt = enc_out[2];
	assign enc_s_filt = enc_out[3];

	// ====================================================================
	// Timer pin-disable source
	// Error path resets to the inactive level; reset selects port_a_bit5 as the kill source
	reg err_meta_q;
	reg err_sync_q;

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			err_meta_q <= 1'b1;
			err_sync_q <= 1'b1;
		end else begin
			err_meta_q <= ~encoder_error;
			err_sync_q <= err_meta_q;
		end
	end

	assign timer_output_kill_n = (~kill_q[`PMUX_POS_KILL_GPIO] & kill_q[`PMUX_POS_KILL_ERR]) ?
	                             err_sync_q : port_a_bit5;

endmodule

// [test/pmux_periph_model.sv]
// Peripheral output and pad model on the far side of the multiplexer
`timescale 1ns/1ps
module pmux_periph_model (
	input  wire        mclk,
	input  wire        rst,
	input  wire [15:0] pad_o,
	input  wire [15:0] pad_oe,
	output wire [15:0] pin_def_o,
	output wire [15:0] pin_def_oe,
	output wire [15:0] pin_opt2_o,
	output wire [15:0] pin_opt2_oe,
	output wire [15:0] pin_opt3_o,
	output wire [15:0] pin_opt3_oe,
	output wire [15:0] pad_i
);
	reg [15:0] q;
	always @(posedge mclk or posedge rst) begin
		if (rst)
			q <= 16'hace1;
		else
			q <= {q[14:0], q[15] ^ q[13] ^ q[12] ^ q[10]};
	end
	assign pin_def_o   = q;
	assign pin_opt2_o  = ~q;
	assign pin_opt3_o  = {q[0], q[15:1]};
	assign pin_def_oe  = {q[3:0], q[15:4]};
	assign pin_opt2_oe = ~pin_def_oe;
	assign pin_opt3_oe = {q[11:0], q[15:12]};
	// Released pad floats to a changing level
	assign pad_i       = (pad_o & pad_oe) | (~pad_oe & {q[10:0], q[15:11]});
endmodule

// [test/pmux_top_asserts.sv]
// Port checker of the pin multiplexer and encoder input filter
`timescale 1ns/1ps
`include "pmux_defs.vh"
module pmux_top_asserts #(
	parameter NPINS = 16,
	parameter QW    = 6
) (
	input wire             mclk,
	input wire             rst,
	input wire [5:0]       avs_address,
	input wire             avs_read,
	input wire             avs_write,
	input wire [31:0]      avs_writedata,
	input wire             avs_priv,
	input wire             avs_waitrequest,
	input wire [1:0]       avs_response,
	input wire [NPINS-1:0] pin_def_o,
	input wire [NPINS-1:0] pin_opt2_o,
	input wire [NPINS-1:0] pin_opt3_o,
	input wire [NPINS-1:0] pad_o,
	input wire [NPINS-1:0] pad_i,
	input wire [NPINS-1:0] periph_in,
	input wire             encoder_phase_a,
	input wire             encoder_phase_b,
	input wire             encoder_error,
	input wire             port_a_bit5,
	input wire             enc_a_filt,
	input wire             enc_b_filt,
	input wire             timer_output_kill_n
);
	// ====================================================================
	// Shadow of the mode registers
	reg  [31:0] filt_q;
	reg  [31:0] kill_q;
	reg  [1:0]  up_q;
	wire        wdone = avs_write & ~avs_waitrequest & avs_priv;
	wire        qa    = ~filt_q[0] & filt_q[1];
	wire        qb    = ~filt_q[8] & filt_q[9];
	wire        ke    = ~kill_q[0] & kill_q[1];
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			filt_q <= `PMUX_RST_FILT;
			kill_q <= `PMUX_RST_KILL;
			up_q   <= 2'h0;
		end else begin
			if (up_q != 2'h3)
				up_q <= up_q + 2'h1;
			if (wdone && avs_address == `PMUX_OFS_FILT)
				filt_q <= avs_writedata;
			if (wdone && avs_address == `PMUX_OFS_KILL)
				kill_q <= avs_writedata;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ====================================================================
	// Assertions
	periph_in_a: assert property (periph_in == pad_i)
		else $error("pad input not fanned out");
	pad_one_a: assert property (((pad_o ^ pin_def_o) & (pad_o ^ pin_opt2_o) & (pad_o ^ pin_opt3_o)) == 0)
		else $error("pad drives no single source");
	pad_rst_a: assert property (up_q == 2'h0 |-> pad_o == pin_def_o)
		else $error("pad not default after reset");
	wait_one_a: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	priv_err_a: assert property (avs_write && !avs_priv && !avs_waitrequest && avs_address == `PMUX_OFS_SEL2
		|-> avs_response == `PMUX_RSP_SLVERR)
		else $error("unprivileged write not refused");
	kill_gpio_a: assert property (!ke |-> timer_output_kill_n == port_a_bit5)
		else $error("kill input not port bit");
	kill_err_a: assert property (ke && up_q == 2'h3 |-> timer_output_kill_n == !$past(encoder_error, 2))
		else $error("kill input not synced error");
	sync_a_a: assert property (!qa && up_q == 2'h3 |-> enc_a_filt == $past(encoder_phase_a, 2))
		else $error("phase a sync wrong");
	sync_b_a: assert property (!qb && up_q == 2'h3 |-> enc_b_filt == $past(encoder_phase_b, 2))
		else $error("phase b sync wrong");
	qual_a_a: assert property (qa && $past(qa) && enc_a_filt != $past(enc_a_filt)
		|-> $past(encoder_phase_a, 3) == $past(encoder_phase_a, 66))
		else $error("qualifier passed short level");
endmodule
bind pmux_top pmux_top_asserts #(.NPINS(NPINS), .QW(QW)) pmux_top_asserts_inst (.mclk, .rst, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_priv, .avs_waitrequest, .avs_response, .pin_def_o, .pin_opt2_o,
	.pin_opt3_o, .pad_o, .pad_i, .periph_in, .encoder_phase_a, .encoder_phase_b, .encoder_error, .port_a_bit5,
	.enc_a_filt, .enc_b_filt, .timer_output_kill_n);

// [test/pmux_top_tb.sv]
// Self-checking bench of the pin multiplexer and input filter
`timescale 1ns/1ps
`include "pmux_defs.vh"
module pmux_top_tb;
	localparam [53:0]  OFS = {`PMUX_OFS_KILL, `PMUX_OFS_FILT, `PMUX_OFS_SEL6, `PMUX_OFS_SEL5, `PMUX_OFS_SEL4,
		`PMUX_OFS_SEL3, `PMUX_OFS_SEL2, `PMUX_OFS_SEL1, `PMUX_OFS_SEL0};
	localparam [287:0] RSV = {`PMUX_RST_KILL, `PMUX_RST_FILT, `PMUX_RST_SEL6, `PMUX_RST_SEL5, `PMUX_RST_SEL4,
		`PMUX_RST_SEL3, `PMUX_RST_SEL2, `PMUX_RST_SEL1, `PMUX_RST_SEL0};
	localparam [287:0] MSK = {`PMUX_MSK_KILL, `PMUX_MSK_FILT, `PMUX_MSK_SEL6, `PMUX_MSK_SEL5, `PMUX_MSK_SEL4,
		`PMUX_MSK_SEL3, `PMUX_MSK_SEL2, `PMUX_MSK_SEL1, `PMUX_MSK_SEL0};
	reg         mclk = 1'b0;
	reg         rst = 1'b1;
	reg  [5:0]  avs_address = 6'h00;
	reg         avs_read = 1'b0;
	reg         avs_write = 1'b0;
	reg  [31:0] avs_writedata = 32'h0;
	reg         avs_priv = 1'b0;
	reg  [4:0]  drv = 5'h00;
	reg  [3:0]  be = 4'hf;
	reg         gpio5 = 1'b0;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	wire [1:0]  avs_response;
	wire [15:0] d_o, d_oe, o2, o2e, o3, o3e, pad_o, pad_oe, pad_i, periph_in;
	wire [3:0]  filt;
	wire        kill_n;
	wire [4:0]  obs = {~kill_n, filt};
	integer     err_count = 0;
	integer     checks_done = 0;
	integer     i, j, k, n;
	reg  [31:0] rdat, v;
	reg  [1:0]  rrsp;
	always #5 mclk = ~mclk;
	pmux_top pmux_top_inst (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_priv(avs_priv),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.pin_def_o(d_o), .pin_def_oe(d_oe), .pin_opt2_o(o2), .pin_opt2_oe(o2e), .pin_opt3_o(o3),
		.pin_opt3_oe(o3e), .pad_o(pad_o), .pad_oe(pad_oe), .pad_i(pad_i), .periph_in(periph_in),
		.encoder_phase_a(drv[0]), .encoder_phase_b(drv[1]), .encoder_index(drv[2]), .encoder_strobe(drv[3]),
		.encoder_error(drv[4]), .port_a_bit5(gpio5), .enc_a_filt(filt[0]), .enc_b_filt(filt[1]),
		.enc_i_filt(filt[2]), .enc_s_filt(filt[3]), .timer_output_kill_n(kill_n));
	pmux_periph_model pmux_periph_model_inst (.mclk(mclk), .rst(rst), .pad_o(pad_o), .pad_oe(pad_oe),
		.pin_def_o(d_o), .pin_def_oe(d_oe), .pin_opt2_o(o2), .pin_opt2_oe(o2e), .pin_opt3_o(o3),
		.pin_opt3_oe(o3e), .pad_i(pad_i));
	// ====================================================================
	// Shared tasks
	task stop_test;
		begin
			$display("checks %0d errors %0d", checks_done, err_count);
			if (err_count == 0 && checks_done > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				$display("ERROR %0t got %h expected %h", $time, got, exp);
				err_count = err_count + 1;
			end
		end
	endtask
	task bus(input wr, input [5:0] a, input [31:0] d, input p);
		begin
			@(posedge mclk);
			avs_read <= ~wr;
			avs_write <= wr;
			avs_address <= a;
			avs_writedata <= d;
			avs_priv <= p;
			n = 0;
			do begin
				@(posedge mclk);
				n = n + 1;
			end while (avs_waitrequest !== 1'b0 && n < 20);
			if (avs_waitrequest !== 1'b0) begin
				$display("ERROR %0t bus timeout", $time);
				err_count = err_count + 1;
				stop_test;
			end
			rdat = avs_readdata;
			rrsp = avs_response;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task pads(input [15:0] s2, input [15:0] s3);
		for (j = 0; j < 4; j = j + 1) begin
			@(negedge mclk);
			chk(pad_o, (o2 & s2) | (o3 & s3) | (d_o & ~(s2 | s3)));
			chk(pad_oe, (o2e & s2) | (o3e & s3) | (d_oe & ~(s2 | s3)));
			chk(periph_in, pad_i);
		end
	endtask
	task meas(input integer c, input b, input integer e);
		begin
			@(posedge mclk);
			drv[c] <= b;
			n = 0;
			do begin
				@(negedge mclk);
				n = n + 1;
			end while (obs[c] !== b && n < 200);
			if (obs[c] !== b) begin
				$display("ERROR %0t filter output timeout", $time);
				err_count = err_count + 1;
				stop_test;
			end
			chk(n, e);
		end
	endtask
	task gp(input b);
		begin
			@(posedge mclk);
			gpio5 <= b;
			@(negedge mclk);
			chk(kill_n, b);
		end
	endtask
	// ====================================================================
	// Scenarios
	task t_regs;
		begin
			pads(16'h0, 16'h0);
			for (i = 0; i < 9; i = i + 1) begin
				bus(0, OFS[i*6 +: 6], 0, 1);
				chk(rdat, RSV[i*32 +: 32]);
				bus(1, OFS[i*6 +: 6], MSK[i*32 +: 32], 1);
				bus(0, OFS[i*6 +: 6], 0, 1);
				chk(rdat, MSK[i*32 +: 32]);
				bus(1, OFS[i*6 +: 6], RSV[i*32 +: 32], 1);
			end
			bus(1, 6'h1c, 32'h1, 1);
			chk(rrsp, `PMUX_RSP_DECERR);
			bus(0, 6'h1c, 0, 1);
			chk(rdat, 32'h0);
			chk(rrsp, `PMUX_RSP_DECERR);
			@(posedge mclk);
			be <= 4'h2;
			bus(1, `PMUX_OFS_SEL1, 32'h02020202, 1);
			be <= 4'hf;
			bus(0, `PMUX_OFS_SEL1, 0, 1);
			chk(rdat, 32'h01010201);
			bus(1, `PMUX_OFS_SEL1, `PMUX_RST_SEL1, 1);
			$display("register test done");
		end
	endtask
	task t_priv;
		begin
			bus(1, `PMUX_OFS_SEL2, 32'h00020000, 0);
			chk(rrsp, `PMUX_RSP_SLVERR);
			bus(0, `PMUX_OFS_SEL2, 0, 1);
			chk(rdat, `PMUX_RST_SEL2);
			pads(16'h0, 16'h0);
			$display("privilege test done");
		end
	endtask
	task t_mux;
		begin
			bus(1, `PMUX_OFS_SEL2, 32'h00020101, 1);
			pads(16'h0080, 16'h0);
			for (i = 0; i < 4; i = i + 1) begin
				v = i == 3 ? 32'h03030303 : {4{i == 1 ? 8'h02 : i == 2 ? 8'h04 : 8'h00}};
				for (k = 0; k < 7; k = k + 1)
					bus(1, OFS[k*6 +: 6], v & MSK[k*32 +: 32], 1);
				pads(i == 1 ? 16'hffff : 16'h0, i == 2 ? `PMUX_HAS_OPT3 : 16'h0);
			end
			$display("mux test done");
		end
	endtask
	task t_filt;
		for (i = 0; i < 4; i = i + 1) begin
			bus(1, `PMUX_OFS_FILT, `PMUX_RST_FILT & ~(32'hff << 8*i), 1);
			meas(i, 1, 3);
			bus(1, `PMUX_OFS_FILT, `PMUX_RST_FILT & ~(32'hff << 8*i) | (32'h2 << 8*i), 1);
			repeat (80) @(posedge mclk);
			drv[i] <= 1'b0;
			repeat (10) @(posedge mclk);
			drv[i] <= 1'b1;
			for (j = 0; j < 70; j = j + 1) begin
				@(negedge mclk);
				chk(filt[i], 1);
			end
			meas(i, 0, 3 + (1 << `PMUX_QUAL_WIDTH));
			bus(1, `PMUX_OFS_FILT, `PMUX_RST_FILT, 1);
			meas(i, 1, 3);
			meas(i, 0, 3);
			$display("filter channel %0d done", i);
		end
	endtask
	task t_kill;
		begin
			gp(1);
			gp(0);
			bus(1, `PMUX_OFS_KILL, 32'h0, 1);
			gp(1);
			gp(0);
			bus(1, `PMUX_OFS_KILL, 32'h2, 1);
			meas(4, 1, 3);
			meas(4, 0, 3);
			bus(1, `PMUX_OFS_KILL, `PMUX_RST_KILL, 1);
			$display("kill source test done");
		end
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_regs;
		t_priv;
		t_mux;
		t_filt;
		t_kill;
		stop_test;
	end
endmodule
